// >>> hw/dcwdt_top.sv
// watchdog timer with apb registers and sampled counting clock
`timescale 1ns/10ps
module dcwdt_top
  import dcwdt_pkg::*;
(
  // clock and resets
  input wire logic i_clk,
  input wire logic i_rst_n,
  input wire logic i_por_n,
  // counting clock, sampled in the bus clock
  input wire logic i_count_clk,
  // apb slave
  input wire logic i_psel,
  input wire logic i_penable,
  input wire logic i_pwrite,
  input wire logic [11:0] i_paddr,
  input wire logic [31:0] i_pwdata,
  output logic [31:0] o_prdata,
  output logic o_pready,
  output logic o_pslverr,
  // system side
  output logic o_chip_reset,
  output logic o_irq,
  output logic o_clk_src_lock
);

  logic cclk_s1;
  logic cclk_s2;
  logic cclk_s3;
  logic tick;
  logic acc;
  logic wr_mode;
  logic wr_tc;
  logic feed_ok;
  logic feed_err;
  logic tmo;
  logic armed;
  logic mode_en;
  logic mode_rst;
  logic active_en;
  logic active_rst;
  logic tof;
  logic irqf;
  logic [23:0] tc;
  logic [23:0] tc_c;
  logic [23:0] cnt;
  logic [23:0] snap;
  logic [23:0] value;
  logic [1:0] pre;
  logic run_c;
  logic uf;
  logic req_tgl;
  logic ack_tgl;
  logic reload;
  logic dec;
  // feed tracker states, one-hot
  typedef enum logic [1:0] {
    FEED_IDLE = 2'b01,
    FEED_ARMED = 2'b10
  } dcwdt_feed_e;
  dcwdt_feed_e feed_state;
  dcwdt_feed_e next_feed_state;

  assign o_pready = 1'b1;
  assign o_pslverr = 1'b0;
  assign acc = i_psel & i_penable;
  assign wr_mode = acc & i_pwrite & (i_paddr == OFS_MODE);
  assign wr_tc = acc & i_pwrite & (i_paddr == OFS_TC);

  // two flops before the edge detector; the first is seen by nothing else
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      cclk_s1 <= 1'b0;
      cclk_s2 <= 1'b0;
      cclk_s3 <= 1'b0;
    end else begin
      cclk_s1 <= i_count_clk;
      cclk_s2 <= cclk_s1;
      cclk_s3 <= cclk_s2;
    end
  end
  assign tick = cclk_s2 & ~cclk_s3;

  // feed tracker: armed by 0xAA, the next access decides
  assign feed_ok = armed & acc & i_pwrite & (i_paddr == OFS_FEED)
                   & (i_pwdata[7:0] == FEED_SECOND);
  assign feed_err = armed & acc & ~feed_ok;
  // errors count only once a feed has started the watchdog
  assign tmo = active_en & (uf | feed_err);

  always_comb begin
    next_feed_state = feed_state;
    case (feed_state)
      FEED_IDLE: begin
        if (acc && i_pwrite && (i_paddr == OFS_FEED) && (i_pwdata[7:0] == FEED_FIRST)) begin
          next_feed_state = FEED_ARMED;
        end
      end
      FEED_ARMED: begin
        if (acc) begin
          next_feed_state = FEED_IDLE;
        end
      end
      default: begin
        next_feed_state = FEED_IDLE;
      end
    endcase
  end

  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      feed_state <= FEED_IDLE;
    end else begin
      feed_state <= next_feed_state;
    end
  end
  assign armed = (feed_state == FEED_ARMED);

  // software view of mode bits: set only, cleared by time-out
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      mode_en <= 1'b0;
      mode_rst <= 1'b0;
    end else if (tmo) begin
      mode_en <= 1'b0;
      mode_rst <= 1'b0;
    end else if (wr_mode) begin
      mode_en <= mode_en | i_pwdata[BIT_RUN_EN];
      mode_rst <= mode_rst | i_pwdata[BIT_RST_EN];
    end
  end
  assign o_clk_src_lock = mode_en;

  // operating copy of the mode, taken only when a feed completes
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      active_en <= 1'b0;
      active_rst <= 1'b0;
    end else if (tmo) begin
      active_en <= 1'b0;
      active_rst <= 1'b0;
    end else if (feed_ok) begin
      active_en <= mode_en;
      active_rst <= mode_rst;
    end
  end

  // time constant with floor
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      tc <= TC_RESET;
    end else if (wr_tc) begin
      tc <= (i_pwdata[23:0] < TC_MIN) ? TC_MIN : i_pwdata[23:0];
    end
  end

  // reload request crosses as a toggle so one feed between ticks is never lost; two feeds between ticks cancel
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      req_tgl <= 1'b0;
    end else if (feed_ok) begin
      req_tgl <= ~req_tgl;
    end
  end

  // time-out flag survives all but the power-on reset; set beats clear
  always_ff @(posedge i_clk) begin
    if (!i_por_n) begin
      tof <= 1'b0;
    end else if (tmo) begin
      tof <= 1'b1;
    end else if (wr_mode && !i_pwdata[BIT_TOF]) begin
      tof <= 1'b0;
    end
  end

  // interrupt flag; in reset mode the chip reset would wipe it anyway
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      irqf <= 1'b0;
    end else if (tmo && !active_rst) begin
      irqf <= 1'b1;
    end
  end
  assign o_irq = irqf;

  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      o_chip_reset <= 1'b0;
    end else begin
      o_chip_reset <= tmo & active_rst;
    end
  end

  // counting logic: acts only on count clock ticks
  assign reload = tick & (req_tgl != ack_tgl);
  assign dec = tick & ~reload & run_c & (pre == PRESCALE_LAST);

  // configuration enters the counting side once per tick, well inside 3 ticks
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      run_c <= 1'b0;
      tc_c <= TC_RESET;
    end else if (tick) begin
      run_c <= active_en;
      tc_c <= tc;
    end
  end

  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      ack_tgl <= 1'b0;
    end else if (reload) begin
      ack_tgl <= req_tgl;
    end
  end

  // prescaler restarts on reload so a fresh period is never short
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      pre <= 2'h0;
    end else if (reload) begin
      pre <= 2'h0;
    end else if (tick && run_c) begin
      pre <= pre + 2'h1;
    end
  end

  // the count holds at zero after an underflow until the next feed
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      cnt <= VALUE_RESET;
    end else if (reload) begin
      cnt <= tc_c;
    end else if (dec && (cnt != 24'h000000)) begin
      cnt <= cnt - 24'h000001;
    end
  end

  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      uf <= 1'b0;
    end else begin
      uf <= dec & (cnt == 24'h000000);
    end
  end

  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      snap <= VALUE_RESET;
    end else if (tick) begin
      snap <= cnt;
    end
  end

  // captured count copied into the bus side register
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      value <= VALUE_RESET;
    end else begin
      value <= snap;
    end
  end

  // read data prepared in the setup phase; reserved bits read zero
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      o_prdata <= 32'h00000000;
    end else if (i_psel && !i_penable && !i_pwrite) begin
      case (i_paddr)
        OFS_MODE: o_prdata <= {28'h0000000, irqf, tof, mode_rst, mode_en};
        OFS_TC: o_prdata <= {8'h00, tc};
        OFS_VALUE: o_prdata <= {8'h00, value};
        default: o_prdata <= 32'h00000000;
      endcase
    end
  end

  a_en_sticky: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    mode_en && !tmo |=> mode_en) else $error("enable bit cleared by software");
  a_tc_floor: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    wr_tc && i_pwdata[23:0] < TC_MIN |=> tc == TC_MIN) else $error("constant floor missed");
  a_irq_level: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    irqf |=> o_irq) else $error("interrupt request dropped");
  a_idle_silent: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    !active_en |=> !o_chip_reset && !$rose(irqf)) else $error("event while disabled");
  a_tmo_clears: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    tmo |=> !mode_en && !mode_rst && !active_en) else $error("enables not cleared");
  a_tof_set: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    tmo |=> tof) else $error("time-out flag not set");
  a_reset_mode: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    tmo && active_rst |=> o_chip_reset && !$rose(irqf)) else $error("reset mode wrong");
  a_int_mode: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    tmo && !active_rst |=> irqf && !o_chip_reset) else $error("interrupt mode wrong");
  a_feed_error: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    armed && acc && !i_pwrite && active_en |-> tmo) else $error("feed error missed");
  a_feed_apply: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    feed_ok && !tmo |=> active_en == $past(mode_en)) else $error("mode not applied");
  a_snap_copy: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    ##1 value == $past(snap)) else $error("value not copied");
  a_rst_sticky: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    mode_rst && !tmo |=> mode_rst) else $error("reset enable cleared by software");
  a_tc_store: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    wr_tc && i_pwdata[23:0] >= TC_MIN |=> tc == $past(i_pwdata[23:0])) else $error("constant lost");
  a_feed_disarm: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    armed && acc |=> !armed) else $error("tracker stayed armed");
  a_tof_clear: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    wr_mode && !i_pwdata[BIT_TOF] && !tmo |=> !tof) else $error("time-out flag not cleared");
  a_stopped_count: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    !run_c && !reload |=> $stable(cnt)) else $error("counter moved while stopped");
  a_prescale_hold: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    tick && run_c && !reload && pre != PRESCALE_LAST |=> $stable(cnt)) else $error("early step");
  a_uf_zero: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    uf |-> cnt == 24'h000000) else $error("underflow away from zero");
  a_cfg_sync: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    tick |=> run_c == $past(active_en)) else $error("enable not carried over");

  c_feed_done: cover property (@(posedge i_clk) disable iff (!i_rst_n) feed_ok && mode_en);
  c_chip_reset: cover property (@(posedge i_clk) disable iff (!i_rst_n) $rose(o_chip_reset));
  c_irq_rise: cover property (@(posedge i_clk) disable iff (!i_rst_n) $rose(o_irq));
  c_underflow: cover property (@(posedge i_clk) disable iff (!i_rst_n) uf && active_en);
  c_feed_error: cover property (@(posedge i_clk) disable iff (!i_rst_n) feed_err && active_en);

endmodule // dcwdt_top

// >>> hw/dcwdt_pkg.sv
// package with register map, field positions and reset values of the watchdog
package dcwdt_pkg;
  localparam logic [11:0] OFS_MODE = 12'h000;
  localparam logic [11:0] OFS_TC = 12'h004;
  localparam logic [11:0] OFS_FEED = 12'h008;
  localparam logic [11:0] OFS_VALUE = 12'h00C;
  localparam int BIT_RUN_EN = 0;
  localparam int BIT_RST_EN = 1;
  localparam int BIT_TOF = 2;
  localparam int BIT_IRQ = 3;
  localparam logic [23:0] TC_MIN = 24'h0000FF;
  localparam logic [23:0] TC_RESET = 24'h0000FF;
  localparam logic [23:0] VALUE_RESET = 24'h0000FF;
  localparam logic [7:0] FEED_FIRST = 8'hAA;
  localparam logic [7:0] FEED_SECOND = 8'h55;
  localparam logic [1:0] PRESCALE_LAST = 2'h3;
endpackage

// >>> verification/dcwdt_host_model.sv
// apb master and chip reset controller model facing the watchdog
`timescale 1ns/10ps
module dcwdt_host_model (
  // clock and bench requests
  input wire logic i_clk,
  input wire logic i_hold_rst,
  // apb master
  output logic o_psel,
  output logic o_penable,
  output logic o_pwrite,
  output logic [11:0] o_paddr,
  output logic [31:0] o_pwdata,
  input wire logic [31:0] i_prdata,
  input wire logic i_pready,
  // reset controller
  input wire logic i_chip_reset,
  output logic o_rst_n,
  output logic [3:0] o_n_resets
);
  logic [3:0] hold;
  initial begin
    o_psel = 1'b0;
    o_penable = 1'b0;
    o_pwrite = 1'b0;
    o_paddr = 12'h000;
    o_pwdata = 32'h0;
  end
  // a chip reset request holds reset low for 12 cycles
  always_ff @(posedge i_clk) begin
    if (i_hold_rst) begin
      hold <= 4'h0;
      o_n_resets <= 4'h0;
    end else if (i_chip_reset === 1'b1) begin
      hold <= 4'hC;
      o_n_resets <= o_n_resets + 4'h1;
    end else if (hold != 4'h0) begin
      hold <= hold - 4'h1;
    end
  end
  assign o_rst_n = !i_hold_rst && (hold == 4'h0);
  // setup, access, then release at the edge where ready is seen
  task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d,
                      output logic [31:0] r);
    int n = 0;
    @(posedge i_clk);
    o_psel <= 1'b1;
    o_penable <= 1'b0;
    o_pwrite <= w;
    o_paddr <= a;
    o_pwdata <= {d[31:8], w && a == 12'h000 ? {4'h0, d[3:0]} : d[7:0]};
    @(posedge i_clk);
    o_penable <= 1'b1;
    do begin
      @(posedge i_clk);
      n++;
    end while (i_pready !== 1'b1 && n < 16);
    r = i_prdata;
    o_psel <= 1'b0;
    o_penable <= 1'b0;
    // a released bus shows no stale address or data
    o_paddr <= ~a;
    o_pwdata <= ~d;
  endtask
endmodule // dcwdt_host_model

// >>> verification/dcwdt_tb_top.sv
// self-checking bench for the watchdog timer
`timescale 1ns/10ps
module dcwdt_tb_top;
  import dcwdt_pkg::*;
  logic clk, cclk, sw_rst, por_n, psel, pen, pwr, pready, slverr, crst, irq, lock, rst_n;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, d, v;
  logic [3:0] nres;
  int fails = 0;
  int n_tests = 0;
  int cyc = 0;
  dcwdt_top dcwdt_top_inst (.i_clk(clk), .i_rst_n(rst_n), .i_por_n(por_n),
    .i_count_clk(cclk), .i_psel(psel), .i_penable(pen), .i_pwrite(pwr), .i_paddr(paddr),
    .i_pwdata(pwdata), .o_prdata(prdata), .o_pready(pready), .o_pslverr(slverr),
    .o_chip_reset(crst), .o_irq(irq), .o_clk_src_lock(lock));
  dcwdt_host_model dcwdt_host_model_inst (.i_clk(clk), .i_hold_rst(sw_rst), .o_psel(psel),
    .o_penable(pen), .o_pwrite(pwr), .o_paddr(paddr), .o_pwdata(pwdata), .i_prdata(prdata),
    .i_pready(pready), .i_chip_reset(crst), .o_rst_n(rst_n), .o_n_resets(nres));
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  // count clock unrelated in phase, each phase exactly two bus cycles long
  initial begin
    cclk = 1'b0;
    #5;
    forever #8 cclk = ~cclk;
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
    n_tests++;
    if (got !== exp) begin
      fails++;
      $display("BAD %0t %s got %h exp %h", $time, m, got, exp);
    end
  endtask
  task automatic rd(input logic [11:0] a, input logic [31:0] exp, input string m);
    logic [31:0] r;
    dcwdt_host_model_inst.xfer(1'b0, a, 32'h0, r);
    chk(r, exp, m);
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] v);
    logic [31:0] r;
    dcwdt_host_model_inst.xfer(1'b1, a, v, r);
  endtask
  function automatic logic [31:0] mexp(logic irqf, logic tof, logic rs, logic en);
    return {28'h0, irqf, tof, rs, en};
  endfunction
  function automatic logic [31:0] tcexp(logic [31:0] v);
    return {8'h0, v[23:0] < TC_MIN ? TC_MIN : v[23:0]};
  endfunction
  task automatic wait_irq(input int lim);
    for (int i = 0; i < lim && irq !== 1'b1; i++) @(posedge clk);
  endtask
  task automatic finish_test;
    $display("checks %0d mismatches %0d", n_tests, fails);
    if (fails == 0 && n_tests > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  always @(posedge clk) begin
    cyc++;
    if (cyc == 30000) begin
      fails++;
      finish_test();
    end
  end
  initial begin
    void'($urandom(4));
    sw_rst = 1'b1;
    por_n = 1'b0;
    repeat (12) @(posedge clk);
    sw_rst <= 1'b0;
    por_n <= 1'b1;
    rd(OFS_MODE, 32'h0, "mode reset");
    rd(OFS_TC, 32'hFF, "tc reset");
    rd(OFS_VALUE, 32'hFF, "value reset");
    d = $urandom % 255;
    wr(OFS_TC, d);
    rd(OFS_TC, tcexp(d), "tc low");
    d = 32'h100 + $urandom % 16;
    wr(OFS_TC, d);
    rd(OFS_TC, tcexp(d), "tc ok");
    $display("test registers done");
    wr(OFS_FEED, 32'hAA);
    wr(OFS_FEED, 32'h55);
    repeat (200) @(posedge clk);
    rd(OFS_VALUE, tcexp(d), "idle value");
    wr(OFS_MODE, 32'h1);
    wr(OFS_MODE, 32'h0);
    rd(OFS_MODE, mexp(0, 0, 0, 1), "set only");
    chk(lock, 1'b1, "lock");
    chk(slverr, 1'b0, "no slave error");
    wr(OFS_FEED, 32'hAA);
    rd(OFS_TC, tcexp(d), "early error");
    repeat (5000) @(posedge clk);
    chk(irq, 1'b0, "no feed no run");
    wr(OFS_FEED, 32'hAA);
    wr(OFS_FEED, 32'h55);
    repeat (300) @(posedge clk);
    dcwdt_host_model_inst.xfer(1'b0, OFS_VALUE, 32'h0, v);
    chk((v < tcexp(d)) && (v + 32'd40 > tcexp(d)), 1'b1, "counting");
    wait_irq(6000);
    chk(irq, 1'b1, "irq mode");
    rd(OFS_MODE, mexp(1, 1, 0, 0), "after timeout");
    repeat (100) @(posedge clk);
    chk(irq, 1'b1, "irq held");
    chk(nres, 4'h0, "no reset in irq mode");
    wr(OFS_MODE, 32'h0);
    rd(OFS_MODE, mexp(1, 0, 0, 0), "tof clear");
    sw_rst <= 1'b1;
    repeat (2) @(posedge clk);
    sw_rst <= 1'b0;
    rd(OFS_MODE, 32'h0, "irq reset");
    $display("test interrupt mode done");
    wr(OFS_MODE, 32'h3);
    wr(OFS_FEED, 32'hAA);
    wr(OFS_FEED, 32'h55);
    wr(OFS_FEED, 32'hAA);
    rd(OFS_TC, {8'h00, TC_RESET}, "bad access");
    repeat (4) @(posedge clk);
    chk(nres, 4'h1, "feed error reset");
    chk(irq, 1'b0, "no irq in reset mode");
    repeat (16) @(posedge clk);
    rd(OFS_MODE, mexp(0, 1, 0, 0), "tof kept");
    por_n <= 1'b0;
    sw_rst <= 1'b1;
    repeat (2) @(posedge clk);
    por_n <= 1'b1;
    sw_rst <= 1'b0;
    rd(OFS_MODE, 32'h0, "power on");
    $display("test reset mode done");
    finish_test();
  end
endmodule // dcwdt_tb_top
